// [src/adcspi_pkg.sv]
// adcspi_pkg: register map, field layout, reset values and timing
// counts for the converter control register bank.
// assumes a 13-bit serial-port address space and 8-bit registers.
package adcspi_pkg;

	// serial frame shape
	localparam int ADDR_W     = 13;
	localparam int DATA_W     = 8;
	localparam int INSTR_BITS = 16;
	localparam int RW_BIT     = 15;

	// register offsets
	localparam logic [12:0] ADDR_INDEX   = 13'h0005;
	localparam logic [12:0] ADDR_PWR     = 13'h0008;
	localparam logic [12:0] ADDR_CHOP    = 13'h000C;
	localparam logic [12:0] ADDR_OMODE   = 13'h0014;
	localparam logic [12:0] ADDR_PHASE   = 13'h0016;
	localparam logic [12:0] ADDR_SERIAL  = 13'h0021;
	localparam logic [12:0] ADDR_CHSTAT  = 13'h0022;
	localparam logic [12:0] ADDR_UIO2    = 13'h0101;
	localparam logic [12:0] ADDR_UIO3    = 13'h0102;
	localparam logic [12:0] ADDR_CALSTAT = 13'h0107;
	localparam logic [12:0] ADDR_CLKMON  = 13'h0112;

	// reset values
	localparam logic [7:0] RST_INDEX  = 8'h33;
	localparam logic [7:0] RST_PWR    = 8'h00;
	localparam logic [7:0] RST_CHOP   = 8'h00;
	localparam logic [7:0] RST_OMODE  = 8'h01;
	localparam logic [7:0] RST_PHASE  = 8'h03;
	localparam logic [7:0] RST_SERIAL = 8'h30;
	localparam logic [7:0] RST_CHSTAT = 8'h00;
	localparam logic [7:0] RST_UIO    = 8'h00;
	localparam logic [7:0] RST_CLKMON = 8'h07;

	// field positions
	localparam int IDX_CHA      = 0;
	localparam int IDX_CHB      = 1;
	localparam int IDX_DATA_CLK = 4;
	localparam int IDX_FRM_CLK  = 5;
	localparam int CHOP_BIT     = 2;
	localparam int OM_FMT_BIT   = 0;
	localparam int OM_INV_BIT   = 2;
	localparam int OM_STD_BIT   = 6;
	localparam int CHPD_BIT     = 0;
	localparam int PD_DIS_BIT   = 0;
	localparam int CM_PD_BIT    = 3;
	localparam int PH_IN_LSB    = 4;
	localparam int SER_MODE_LSB = 4;
	localparam int REC_LSB      = 3;

	// write masks: open and fixed bits read back as zero or fixed
	localparam logic [7:0] MASK_INDEX  = 8'h33;
	localparam logic [7:0] MASK_PWR    = 8'h03;
	localparam logic [7:0] MASK_CHOP   = 8'h04;
	localparam logic [7:0] MASK_OMODE  = 8'h45;
	localparam logic [7:0] MASK_PHASE  = 8'h7F;
	localparam logic [7:0] MASK_CHSTAT = 8'h01;
	localparam logic [7:0] MASK_UIO2   = 8'h01;
	localparam logic [7:0] MASK_UIO3   = 8'h08;
	localparam logic [7:0] MASK_CLKMON = 8'h3F;

	// power mode codes
	typedef enum logic [1:0] {
		PWR_NORMAL  = 2'b00,
		PWR_DOWN    = 2'b01,
		PWR_STANDBY = 2'b10,
		PWR_DRESET  = 2'b11
	} adcspi_pwr_t;

	localparam logic [2:0] REC_ON  = 3'b101;
	localparam logic [2:0] REC_OFF = 3'b000;

	// timing counts, in converter clock cycles
	localparam int CAL_CYCLES   = 32'h0000_0400;
	localparam int RECOV_CYCLES = 32'h01D9_05C0;

endpackage : adcspi_pkg

// [src/adcspi_sync.sv]
// adcspi_sync: two-flop synchroniser for one asynchronous level.
// assumes the input may change at any time relative to clk.
`timescale 1ns/1ps
module adcspi_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// level in and out
	input  wire logic async_in,
	output logic      sync_out
);

	logic meta_r;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r   <= RST_VAL;
			sync_out <= RST_VAL;
		end
		else
		begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : adcspi_sync

// [src/adcspi_port.sv]
// adcspi_port: serial control port slave, oversampled on clk.
// assumes sclk, csb and sdio are already synchronised and that
// sclk runs at most clk/4; 16-bit instruction, msb first, then
// data bytes at descending addresses.
`timescale 1ns/1ps
module adcspi_port (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// synchronised pins
	input  wire logic        sclk_s,
	input  wire logic        csb_s,
	input  wire logic        sdio_s,
	output logic             sdio_out,
	output logic             sdio_oe_n,
	// register side
	output logic             wr_stb,
	output logic [12:0]      acc_addr,
	output logic [7:0]       wr_data,
	input  wire logic [7:0]  rd_data
);

	logic        sclk_d_r;
	logic [4:0]  bit_cnt_r;
	logic        data_ph_r;
	logic        rd_r;
	logic [15:0] shin_r;
	logic [7:0]  shout_r;
	logic        rise;
	logic        fall;

	assign rise = sclk_s & ~sclk_d_r;
	assign fall = ~sclk_s & sclk_d_r;

	// edge history of the serial clock
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sclk_d_r <= 1'b0;
		else
			sclk_d_r <= sclk_s;
	end

	// receive: instruction then data bytes
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_cnt_r <= 5'h00;
			data_ph_r <= 1'b0;
			rd_r      <= 1'b0;
			shin_r    <= 16'h0000;
			acc_addr  <= 13'h0000;
			wr_data   <= 8'h00;
			wr_stb    <= 1'b0;
		end
		else
		begin
			wr_stb <= 1'b0;
			if (csb_s)
			begin
				bit_cnt_r <= 5'h00;
				data_ph_r <= 1'b0;
			end
			else if (rise)
			begin
				shin_r <= {shin_r[14:0], sdio_s};
				if (!data_ph_r && bit_cnt_r == 5'(adcspi_pkg::INSTR_BITS - 1))
				begin
					rd_r      <= shin_r[adcspi_pkg::RW_BIT - 1];
					acc_addr  <= {shin_r[11:0], sdio_s};
					data_ph_r <= 1'b1;
					bit_cnt_r <= 5'h00;
				end
				else if (data_ph_r && bit_cnt_r == 5'h07)
				begin
					// one byte done: write it unless reading, step to the next address
					bit_cnt_r <= 5'h00;
					wr_data   <= {shin_r[6:0], sdio_s};
					wr_stb    <= ~rd_r;
					if (rd_r)
						acc_addr <= acc_addr - 13'h0001;
				end
				else
					bit_cnt_r <= bit_cnt_r + 5'h01;
			end
			else if (wr_stb)
				acc_addr <= acc_addr - 13'h0001;
		end
	end

	// transmit on falling edges; read data loaded at byte start
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shout_r   <= 8'h00;
			sdio_out  <= 1'b0;
			sdio_oe_n <= 1'b1;
		end
		else if (csb_s || !data_ph_r || !rd_r)
			sdio_oe_n <= 1'b1;
		else if (fall)
		begin
			sdio_oe_n <= 1'b0;
			if (bit_cnt_r == 5'h00)
			begin
				shout_r  <= {rd_data[6:0], 1'b0};
				sdio_out <= rd_data[7];
			end
			else
			begin
				shout_r  <= {shout_r[6:0], 1'b0};
				sdio_out <= shout_r[7];
			end
		end
	end

endmodule : adcspi_port

// [src/adcspi_ctrl.sv]
// adcspi_ctrl: control register bank of a dual-channel converter,
// programmed through the serial control port.
// assumes rst_n is the power-on reset and clk is the converter clock;
// glitch_det comes from the analog clock monitor, asynchronously.
`timescale 1ns/1ps
module adcspi_ctrl #(
	parameter int CAL_CYCLES   = adcspi_pkg::CAL_CYCLES,
	parameter int RECOV_CYCLES = adcspi_pkg::RECOV_CYCLES
) (
	// clock and power-on reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// serial control port pins
	input  wire logic       sclk,
	input  wire logic       csb,
	input  wire logic       sdio_in,
	output logic            sdio_out,
	output logic            sdio_oe_n,
	// clock monitor
	input  wire logic       glitch_det,
	// datapath and output control
	output logic            dp_clk_en,
	output logic            dp_rst,
	output logic            out_en,
	output logic            cal_busy,
	output logic [1:0]      chan_pd,
	output logic [1:0]      chop_en,
	output logic [1:0]      reduced_swing,
	output logic [1:0]      out_invert,
	output logic [1:0]      twos_comp,
	output logic [2:0]      in_clk_phase,
	output logic [3:0]      data_clk_phase,
	output logic [2:0]      serial_mode,
	output logic            serial_cfg_msb,
	output logic            sdio_pd_dis,
	output logic            cm_gen_pd
);

	// synchronised pins
	logic sclk_s;
	logic csb_s;
	logic sdio_s;
	logic glitch_s;

	// port side
	logic        wr_stb;
	logic [12:0] acc_addr;
	logic [7:0]  wr_data;
	logic [7:0]  rd_data;

	// register state
	logic [7:0] index_r;
	logic [1:0] pwr_r;
	logic [7:0] chop_r   [2];
	logic [7:0] omode_r  [2];
	logic [7:0] chstat_r [2];
	logic [7:0] phase_r;
	logic [7:0] serial_r;
	logic [7:0] uio2_r;
	logic [7:0] uio3_r;
	logic [7:0] clkmon_r;

	// calibration and recovery
	logic [31:0] cal_cnt_r;
	logic [31:0] rec_cnt_r;
	logic        glitch_d_r;
	logic        rec_busy;
	logic        sel_a;
	logic [1:0]  ch_sel;
	adcspi_pkg::adcspi_pwr_t pwr_mode;

	assign pwr_mode = adcspi_pkg::adcspi_pwr_t'(pwr_r);
	assign rec_busy = (rec_cnt_r != 32'h0000_0000);

	// pins cross into clk before any logic reads them
	adcspi_sync #(.RST_VAL(1'b0)) u_sync_sclk (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (sclk),
		.sync_out (sclk_s)
	);
	adcspi_sync #(.RST_VAL(1'b1)) u_sync_csb (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (csb),
		.sync_out (csb_s)
	);
	adcspi_sync #(.RST_VAL(1'b0)) u_sync_sdio (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (sdio_in),
		.sync_out (sdio_s)
	);
	adcspi_sync #(.RST_VAL(1'b0)) u_sync_glitch (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (glitch_det),
		.sync_out (glitch_s)
	);

	adcspi_port u_port (
		.clk       (clk),
		.rst_n     (rst_n),
		.sclk_s    (sclk_s),
		.csb_s     (csb_s),
		.sdio_s    (sdio_s),
		.sdio_out  (sdio_out),
		.sdio_oe_n (sdio_oe_n),
		.wr_stb    (wr_stb),
		.acc_addr  (acc_addr),
		.wr_data   (wr_data),
		.rd_data   (rd_data)
	);

	assign ch_sel = {index_r[adcspi_pkg::IDX_CHB], index_r[adcspi_pkg::IDX_CHA]};
	// reads of a local register show channel a unless only b is picked
	assign sel_a  = index_r[adcspi_pkg::IDX_CHA] | ~index_r[adcspi_pkg::IDX_CHB];

	// global registers, written whatever the index holds
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			index_r  <= adcspi_pkg::RST_INDEX;
			pwr_r    <= adcspi_pkg::RST_PWR[1:0];
			serial_r <= adcspi_pkg::RST_SERIAL;
			uio2_r   <= adcspi_pkg::RST_UIO;
			uio3_r   <= adcspi_pkg::RST_UIO;
			clkmon_r <= adcspi_pkg::RST_CLKMON;
		end
		else if (wr_stb)
		begin
			unique case (acc_addr)
				adcspi_pkg::ADDR_INDEX:  index_r  <= wr_data & adcspi_pkg::MASK_INDEX;
				adcspi_pkg::ADDR_PWR:    pwr_r    <= wr_data[1:0];
				adcspi_pkg::ADDR_SERIAL: serial_r <= wr_data;
				adcspi_pkg::ADDR_UIO2:   uio2_r   <= wr_data & adcspi_pkg::MASK_UIO2;
				adcspi_pkg::ADDR_UIO3:   uio3_r   <= wr_data & adcspi_pkg::MASK_UIO3;
				adcspi_pkg::ADDR_CLKMON: clkmon_r <= wr_data & adcspi_pkg::MASK_CLKMON;
				default:                 ;
			endcase
		end
	end

	// data clock phase follows the clock select bit
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			phase_r <= adcspi_pkg::RST_PHASE;
		else if (wr_stb && acc_addr == adcspi_pkg::ADDR_PHASE)
		begin
			phase_r[6:4] <= wr_data[6:4];
			if (index_r[adcspi_pkg::IDX_DATA_CLK])
				phase_r[3:0] <= wr_data[3:0];
		end
	end

	// local copies, one per selected channel
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 2; i++)
			begin
				chop_r[i]   <= adcspi_pkg::RST_CHOP;
				omode_r[i]  <= adcspi_pkg::RST_OMODE;
				chstat_r[i] <= adcspi_pkg::RST_CHSTAT;
			end
		end
		else if (wr_stb)
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (ch_sel[i])
				begin
					if (acc_addr == adcspi_pkg::ADDR_CHOP)
						chop_r[i] <= wr_data & adcspi_pkg::MASK_CHOP;
					if (acc_addr == adcspi_pkg::ADDR_OMODE)
						omode_r[i] <= wr_data & adcspi_pkg::MASK_OMODE;
					if (acc_addr == adcspi_pkg::ADDR_CHSTAT)
						chstat_r[i] <= wr_data & adcspi_pkg::MASK_CHSTAT;
				end
			end
		end
	end

	// calibration at power-up and digital reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cal_cnt_r <= 32'(CAL_CYCLES);
		else if (wr_stb && acc_addr == adcspi_pkg::ADDR_PWR && wr_data[1:0] == adcspi_pkg::PWR_DRESET)
			cal_cnt_r <= 32'(CAL_CYCLES);
		else if (rec_cnt_r == 32'h0000_0001)
			cal_cnt_r <= 32'(CAL_CYCLES);
		else if (cal_cnt_r != 32'h0000_0000 && pwr_mode != adcspi_pkg::PWR_DRESET)
			cal_cnt_r <= cal_cnt_r - 32'h0000_0001;
	end

	// automatic recovery after a detected glitch
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			glitch_d_r <= 1'b0;
			rec_cnt_r  <= 32'h0000_0000;
		end
		else
		begin
			glitch_d_r <= glitch_s;
			if (glitch_s && !glitch_d_r && !rec_busy
				&& clkmon_r[adcspi_pkg::REC_LSB +: 3] == adcspi_pkg::REC_ON)
				rec_cnt_r <= 32'(RECOV_CYCLES) - 32'(CAL_CYCLES);
			else if (rec_busy)
				rec_cnt_r <= rec_cnt_r - 32'h0000_0001;
		end
	end

	// power mode decode to datapath controls
	always_comb
	begin
		dp_clk_en = 1'b1;
		dp_rst    = rec_busy;
		out_en    = ~rec_busy;
		unique case (pwr_mode)
			adcspi_pkg::PWR_NORMAL:  ;
			adcspi_pkg::PWR_DOWN:
			begin
				dp_clk_en = 1'b0;
				dp_rst    = 1'b1;
				out_en    = 1'b0;
			end
			adcspi_pkg::PWR_STANDBY:
			begin
				dp_clk_en = 1'b0;
				out_en    = 1'b0;
			end
			adcspi_pkg::PWR_DRESET:
			begin
				dp_rst = 1'b1;
				out_en = 1'b0;
			end
		endcase
	end

	assign cal_busy = (cal_cnt_r != 32'h0000_0000);

	// per-channel outputs
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			chan_pd[i]       = chstat_r[i][adcspi_pkg::CHPD_BIT];
			chop_en[i]       = chop_r[i][adcspi_pkg::CHOP_BIT];
			reduced_swing[i] = omode_r[i][adcspi_pkg::OM_STD_BIT];
			out_invert[i]    = omode_r[i][adcspi_pkg::OM_INV_BIT];
			twos_comp[i]     = omode_r[i][adcspi_pkg::OM_FMT_BIT];
		end
	end

	// sampling phase delay in input clocks
	assign in_clk_phase   = phase_r[adcspi_pkg::PH_IN_LSB +: 3];
	assign data_clk_phase = phase_r[3:0];
	assign serial_mode    = serial_r[adcspi_pkg::SER_MODE_LSB +: 3];
	assign serial_cfg_msb = serial_r[7];
	assign sdio_pd_dis    = uio2_r[adcspi_pkg::PD_DIS_BIT];
	assign cm_gen_pd      = uio3_r[adcspi_pkg::CM_PD_BIT];

	// read mux; unmapped addresses read zero
	always_comb
	begin
		rd_data = 8'h00;
		unique case (acc_addr)
			adcspi_pkg::ADDR_INDEX:   rd_data = index_r;
			adcspi_pkg::ADDR_PWR:     rd_data = {6'h00, pwr_r};
			adcspi_pkg::ADDR_CHOP:    rd_data = sel_a ? chop_r[0] : chop_r[1];
			adcspi_pkg::ADDR_OMODE:   rd_data = sel_a ? omode_r[0] : omode_r[1];
			adcspi_pkg::ADDR_PHASE:   rd_data = phase_r;
			adcspi_pkg::ADDR_SERIAL:  rd_data = serial_r;
			adcspi_pkg::ADDR_CHSTAT:  rd_data = sel_a ? chstat_r[0] : chstat_r[1];
			adcspi_pkg::ADDR_UIO2:    rd_data = uio2_r;
			adcspi_pkg::ADDR_UIO3:    rd_data = uio3_r;
			// reads zero once calibration is done
			adcspi_pkg::ADDR_CALSTAT: rd_data = {6'h00, cal_busy, cal_busy};
			adcspi_pkg::ADDR_CLKMON:  rd_data = clkmon_r;
			default:                  rd_data = 8'h00;
		endcase
	end

endmodule : adcspi_ctrl

// [testbench/adcspi_monitor.sv]
// adcspi_monitor: port checks for the control register bank.
// assumes a host that holds csb low a few clocks past its last sclk rise.
`timescale 1ns/1ps
module adcspi_monitor #(
	parameter int CAL_CYCLES = 16
) (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// serial pins
	input wire logic       csb,
	input wire logic       sdio_oe_n,
	// datapath control
	input wire logic       dp_clk_en,
	input wire logic       dp_rst,
	input wire logic       out_en,
	input wire logic       cal_busy,
	// configuration levels
	input wire logic [1:0] chop_en,
	input wire logic [1:0] out_invert,
	input wire logic [1:0] twos_comp,
	input wire logic [2:0] serial_mode
);
	// two clocks of slack on the countdown edges
	localparam int CAL_LIM = CAL_CYCLES + 2;
	property p_gate_out;
		@(posedge clk) disable iff (!rst_n) !dp_clk_en |-> !out_en;
	endproperty
	a_gate_out: assert property (p_gate_out) else $error("outputs live with clocks stopped");
	property p_rst_out;
		@(posedge clk) disable iff (!rst_n) dp_rst |-> !out_en;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs live during datapath reset");
	property p_cal_end;
		@(posedge clk) disable iff (!rst_n) cal_busy && !dp_rst && dp_clk_en |-> ##[1:CAL_LIM] !cal_busy;
	endproperty
	a_cal_end: assert property (p_cal_end) else $error("calibration overran its count");
	property p_idle_sdio;
		@(posedge clk) disable iff (!rst_n) csb [*5] |-> sdio_oe_n;
	endproperty
	a_idle_sdio: assert property (p_idle_sdio) else $error("sdio driven while deselected");
	property p_oe_frame;
		@(posedge clk) disable iff (!rst_n) !sdio_oe_n |-> !$past(csb, 6);
	endproperty
	a_oe_frame: assert property (p_oe_frame) else $error("sdio driven outside a frame");
	property p_chop_wr;
		@(posedge clk) disable iff (!rst_n) $changed(chop_en) |-> !$past(csb, 2);
	endproperty
	a_chop_wr: assert property (p_chop_wr) else $error("chop changed without a write");
	property p_inv_wr;
		@(posedge clk) disable iff (!rst_n) $changed(out_invert) |-> !$past(csb, 2);
	endproperty
	a_inv_wr: assert property (p_inv_wr) else $error("invert changed without a write");
	property p_fmt_wr;
		@(posedge clk) disable iff (!rst_n) $changed(twos_comp) |-> !$past(csb, 2);
	endproperty
	a_fmt_wr: assert property (p_fmt_wr) else $error("format changed without a write");
	property p_mode_wr;
		@(posedge clk) disable iff (!rst_n) $changed(serial_mode) |-> !$past(csb, 2);
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("serial mode changed without a write");
endmodule : adcspi_monitor

bind adcspi_ctrl adcspi_monitor #(.CAL_CYCLES(CAL_CYCLES)) u_mon (.clk, .rst_n, .csb, .sdio_oe_n, .dp_clk_en,
	.dp_rst, .out_en, .cal_busy, .chop_en, .out_invert, .twos_comp, .serial_mode);

// [testbench/adcspi_host.sv]
// adcspi_host: serial control port host, one 24-bit frame per call.
// assumes clk is the converter clock; sclk low lasts four clocks, sclk high five.
`timescale 1ns/1ps
module adcspi_host (
	// clock
	input wire logic clk,
	// serial pins
	output logic     sclk,
	output logic     csb,
	output logic     sdo,
	input wire logic sdio
);
	initial
	begin
		sclk = 1'b0;
		csb  = 1'b1;
		sdo  = 1'b0;
	end
	// drive on sclk low, sample on sclk high once the device has settled
	task automatic xfer(input logic [23:0] frame, output logic [7:0] rd);
		int i;
		rd = 8'h00;
		@(posedge clk);
		csb <= 1'b0;
		for (i = 23; i >= 0; i--)
		begin
			@(posedge clk);
			sclk <= 1'b0;
			sdo  <= frame[i];
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
			#1;
			if (i < 8)
				rd[i] = sdio;
		end
		// csb stays low past the write strobe, then the line is let go
		repeat (8) @(posedge clk);
		csb <= 1'b1;
		sdo <= ~sdo;
		repeat (6) @(posedge clk);
	endtask : xfer
endmodule : adcspi_host

// [testbench/testbench.sv]
// testbench: register bank scenarios through the serial control port.
// assumes the host model paces sclk and the monitor is bound to the design.
`timescale 1ns/1ps
module testbench;
	localparam int CAL   = 16;
	localparam int REC   = 100;
	localparam int LIMIT = 40000;
	logic       clk, rst_n, glitch_det, sclk, csb, sdo, sdio_in, sdio_out, sdio_oe_n;
	logic       dp_clk_en, dp_rst, out_en, cal_busy, serial_cfg_msb, sdio_pd_dis, cm_gen_pd;
	logic [1:0] chan_pd, chop_en, reduced_swing, out_invert, twos_comp;
	logic [2:0] in_clk_phase, serial_mode;
	logic [3:0] data_clk_phase;
	logic [12:0] ra [9] = '{13'h0005, 13'h0008, 13'h000C, 13'h0014, 13'h0016, 13'h0021, 13'h0101,
		13'h0102, 13'h0112};
	logic [7:0]  rv [9] = '{8'h33, 8'h00, 8'h00, 8'h01, 8'h03, 8'h30, 8'h00, 8'h00, 8'h07};
	int         fail_count = 0;
	int         checked = 0;
	int         cyc = 0;
	int         k;

	adcspi_ctrl #(.CAL_CYCLES(CAL), .RECOV_CYCLES(REC)) dut (.clk, .rst_n, .sclk, .csb, .sdio_in, .sdio_out,
		.sdio_oe_n, .glitch_det, .dp_clk_en, .dp_rst, .out_en, .cal_busy, .chan_pd, .chop_en, .reduced_swing,
		.out_invert, .twos_comp, .in_clk_phase, .data_clk_phase, .serial_mode, .serial_cfg_msb, .sdio_pd_dis,
		.cm_gen_pd);
	adcspi_host host (.clk, .sclk, .csb, .sdo, .sdio(sdio_in));

	// shared sdio wire: device wins while it drives
	assign sdio_in = sdio_oe_n ? sdo : sdio_out;

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			fail_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] dummy;
		host.xfer({3'b000, a, d}, dummy);
	endtask : wr

	task automatic rchk(input logic [12:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.xfer({3'b100, a, 8'h00}, d);
		chk(d, exp);
	endtask : rchk

	// bounded wait for calibration and recovery to finish
	task automatic wait_idle();
		int n;
		for (n = 0; n < REC + CAL + 40 && (cal_busy !== 1'b0 || dp_rst !== 1'b0); n++)
			@(posedge clk);
	endtask : wait_idle

	task automatic glitch();
		glitch_det <= 1'b1;
		repeat (4) @(posedge clk);
		glitch_det <= 1'b0;
		repeat (10) @(posedge clk);
	endtask : glitch

	// status view: clock enable, datapath reset, output enable
	function automatic logic [7:0] st();
		return {5'h00, dp_clk_en, dp_rst, out_en};
	endfunction : st

	initial
	begin
		rst_n      = 1'b0;
		glitch_det = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({7'h00, cal_busy}, 8'h01);
		wait_idle();
		rchk(13'h0107, 8'h00);
		for (k = 0; k < 9; k++)
			rchk(ra[k], rv[k]);
		chk({twos_comp, 2'b00, data_clk_phase}, 8'hC3);
		chk({5'h00, serial_mode}, 8'h03);
		$display("test reset_values done");
		wr(13'h0005, 8'h02);
		wr(13'h000C, 8'h04);
		chk({6'h00, chop_en}, 8'h02);
		rchk(13'h000C, 8'h04);
		wr(13'h0005, 8'h01);
		rchk(13'h000C, 8'h00);
		wr(13'h0005, 8'h03);
		wr(13'h0014, 8'h44);
		chk({2'b00, reduced_swing, out_invert, twos_comp}, 8'h3C);
		wr(13'h0014, 8'h01);
		chk({2'b00, reduced_swing, out_invert, twos_comp}, 8'h03);
		$display("test channel_select done");
		wr(13'h0005, 8'h01);
		// sdr codes only as register values; no sample clock runs here
		for (k = 0; k < 5; k++)
		begin
			wr(13'h0021, 8'(k << 4));
			chk({5'h00, serial_mode}, 8'(k));
		end
		// top bit of the serial format register
		wr(13'h0021, 8'hB0);
		chk({serial_cfg_msb, 4'h0, serial_mode}, 8'h83);
		// data clock select bit clear, so the data clock phase keeps its reset value 3
		for (k = 0; k < 8; k++)
		begin
			wr(13'h0016, 8'((k << 4) | 8'h0B));
			chk({in_clk_phase, 1'b0, data_clk_phase}, 8'((k << 5) | 3));
		end
		wr(13'h0005, 8'h33);
		wr(13'h0016, 8'h0B);
		chk({4'h0, data_clk_phase}, 8'h0B);
		$display("test global_fields done");
		// power down b: index, local bit, then digital reset
		wr(13'h0005, 8'h02);
		wr(13'h0022, 8'h01);
		wr(13'h0005, 8'h31);
		wr(13'h0008, 8'h03);
		chk(st(), 8'h06);
		rchk(13'h0107, 8'h03);
		wr(13'h0008, 8'h00);
		wait_idle();
		chk(st(), 8'h05);
		chk({6'h00, chan_pd}, 8'h02);
		rchk(13'h0107, 8'h00);
		// power-down, then standby, once calibration is done
		wr(13'h0008, 8'h01);
		chk(st(), 8'h02);
		chk({7'h00, cal_busy}, 8'h00);
		wr(13'h0008, 8'h02);
		chk(st(), 8'h00);
		wr(13'h0008, 8'h00);
		wait_idle();
		chk(st(), 8'h05);
		$display("test power_modes done");
		wr(13'h0101, 8'hFF);
		chk({7'h00, sdio_pd_dis}, 8'h01);
		wr(13'h0102, 8'hFF);
		chk({7'h00, cm_gen_pd}, 8'h01);
		rchk(13'h0102, 8'h08);
		wr(13'h0107, 8'hFF);
		rchk(13'h0107, 8'h00);
		$display("test user_io done");
		glitch();
		chk(st(), 8'h05);
		// recovery off: the host restores with a digital reset
		wr(13'h0008, 8'h03);
		wr(13'h0008, 8'h00);
		wait_idle();
		wr(13'h0112, 8'h2F);
		glitch();
		chk(st(), 8'h06);
		// fixed bound: pin raised 14 clocks ago, sync adds 3, total REC
		repeat (REC - 10) @(posedge clk);
		chk(st(), 8'h05);
		chk({7'h00, cal_busy}, 8'h00);
		$display("test clock_recovery done");
		stop_test();
	end
endmodule : testbench
